/* File: logic/flash_seq_defines.svh */
// Purpose: Named constants for the flash self-programming sequencer
// Assumes: Seven-bit command codes, 16-bit byte pointer
// Notes:   Included by the sequencer only, not by the package
`ifndef FLASH_SEQ_DEFINES_SVH
`define FLASH_SEQ_DEFINES_SVH

`define CMD_W              7
`define CMD_NOP            7'h00
`define CMD_READ_USER_SIG  7'h01
`define CMD_READ_CALIB     7'h02
`define CMD_READ_FUSES     7'h07
`define CMD_WRITE_LOCK     7'h08
`define CMD_ERASE_USER_SIG 7'h18
`define CMD_WRITE_USER_SIG 7'h1A
`define CMD_ERASE_APP      7'h20
`define CMD_ERASE_APP_PG   7'h22
`define CMD_LOAD_FBUF      7'h23
`define CMD_WRITE_APP_PG   7'h24
`define CMD_ERWR_APP_PG    7'h25
`define CMD_ERASE_FBUF     7'h26
`define CMD_ERASE_BOOT_PG  7'h2A
`define CMD_ERASE_FL_PG    7'h2B
`define CMD_WRITE_BOOT_PG  7'h2C
`define CMD_ERWR_BOOT_PG   7'h2D
`define CMD_WRITE_FL_PG    7'h2E
`define CMD_ERWR_FL_PG     7'h2F

`define PTR_W              16
`define WORD_LSB           1
`define ERASED_WORD        16'hFFFF
`define LOCK_RESET         8'hFF

`endif

/* File: logic/flash_seq_pkg.sv */
// Purpose: Types shared by the flash self-programming sequencer
// Assumes: Constants come from flash_seq_defines.svh
// Notes:   States carry no explicit codes
package flash_seq_pkg;

  typedef enum logic [2:0]
  {
    S_IDLE,
    S_ERASE,
    S_PROG,
    S_CLEAR,
    S_FUSE,
    S_LOCK
  } seq_state_t;

  typedef logic [6:0] cmd_t;

endpackage

/* File: logic/flash_self_program_sequencer.sv */
// Purpose: Command sequencer for flash self-programming, rows, fuses, locks
// Assumes: Triggers are one-cycle pulses from core logic on i_clk
// Notes:   Flash array, rows and fuses sit outside; page buffer is here
`timescale 1ns/10ps
`include "flash_seq_defines.svh"

module flash_self_program_sequencer
#(
  parameter int WORD_BITS    = 6,
  parameter int BOOT_PAGE    = 480,
  parameter int ERASE_CYCLES = 16,
  parameter int CNT_W        = 16
)
(
  input  wire logic                         i_clk,
  input  wire logic                         i_rstn,
  input  wire flash_seq_pkg::cmd_t          i_cmd,
  input  wire logic                         i_command_execute_bit,
  input  wire logic                         i_store_program_memory_instr,
  input  wire logic                         i_load_program_memory_instr,
  input  wire logic                         i_change_protection_sequence,
  input  wire logic [`PTR_W-1:0]            i_pointer,
  input  wire logic [15:0]                  i_data_word_register_pair,
  input  wire logic [7:0]                   i_data_byte_zero_reg,
  input  wire logic [7:0]                   i_fuse_addr,
  input  wire logic [7:0]                   i_row_rdata,
  input  wire logic [7:0]                   i_fuse_rdata,
  output logic                              o_busy,
  output logic                              o_flash_section_busy_flag,
  output logic                              o_app_blocked,
  output logic                              o_cpu_halt,
  output logic                              o_abort,
  output logic                              o_erase_req,
  output logic                              o_erase_all_app,
  output logic                              o_erase_sig,
  output logic                              o_prog_we,
  output logic                              o_prog_sig,
  output logic [`PTR_W-WORD_BITS-2:0]       o_page,
  output logic [WORD_BITS-1:0]              o_prog_word,
  output logic [15:0]                       o_prog_data,
  output logic                              o_row_rd,
  output logic                              o_row_cal,
  output logic [`PTR_W-1:0]                 o_row_addr,
  output logic [7:0]                        o_row_data,
  output logic                              o_row_valid,
  output logic                              o_fuse_rd,
  output logic [7:0]                        o_fuse_addr,
  output logic [7:0]                        o_data_byte_zero_reg,
  output logic [7:0]                        o_lock_bits,
  output logic                              o_eeprom_buf_erase
);
  import flash_seq_pkg::*;

  localparam int PAGE_WORDS = 1 << WORD_BITS;
  localparam int PG_W       = `PTR_W - WORD_BITS - 1;
  localparam int PG_LSB     = WORD_BITS + `WORD_LSB;

  ////////////////////////////////////////////////////////////////////////
  // Reset release
  logic [1:0] rst_sync;
  logic       rstn;

  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rstn = rst_sync[1];

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic [PG_W-1:0]      ptr_page;
  logic [WORD_BITS-1:0] ptr_word;
  logic                 in_app;
  logic                 idle;
  logic                 spm_ok;
  logic                 cex_ok;

  // Page bits only
  // pointer page bits
  assign ptr_page = i_pointer[`PTR_W-1:PG_LSB];
  assign ptr_word = i_pointer[PG_LSB-1:`WORD_LSB];
  assign in_app   = ptr_page < PG_W'(BOOT_PAGE);

  seq_state_t state;
  assign idle   = (state == S_IDLE);
  assign spm_ok = idle && i_store_program_memory_instr
                  && i_change_protection_sequence;
  assign cex_ok = idle && i_command_execute_bit
                  && i_change_protection_sequence;

  ////////////////////////////////////////////////////////////////////////
  // Page buffer
  logic [15:0]          pbuf [PAGE_WORDS];
  logic                 buf_we;
  logic [WORD_BITS-1:0] buf_idx;
  logic [15:0]          buf_wdata;

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int w = 0; w < PAGE_WORDS; w++)
        pbuf[w] <= `ERASED_WORD;
    end
    else if (buf_we)
      pbuf[buf_idx] <= buf_wdata;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sequencer
  seq_state_t       next_state;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [PG_W-1:0]  next_page;
  logic             prog_after, next_prog_after;
  logic             sig_op, next_sig_op;
  logic             halt_prog, next_halt_prog;
  logic             next_busy, next_flash_section_busy_flag, next_halt, next_abort;
  logic             next_erase_req, next_erase_all, next_erase_sig;
  logic             next_prog_we, next_prog_sig;
  logic [WORD_BITS-1:0] next_prog_word;
  logic [15:0]      next_prog_data;
  logic             next_row_rd, next_row_cal, next_row_valid;
  logic [`PTR_W-1:0] next_row_addr;
  logic [7:0]       next_row_data;
  logic             next_fuse_rd, fuse_pend, next_fuse_pend;
  logic [7:0]       next_fuse_addr, next_dbz, next_lock;
  logic             next_ee_erase;

  always_comb
  begin
    next_state      = state;
    next_cnt        = cnt;
    next_page       = o_page;
    next_prog_after = prog_after;
    next_sig_op     = sig_op;
    next_halt_prog  = halt_prog;
    next_abort      = 1'b0;
    next_erase_req  = 1'b0;
    next_erase_all  = 1'b0;
    next_erase_sig  = 1'b0;
    next_prog_we    = 1'b0;
    next_prog_sig   = o_prog_sig;
    next_prog_word  = o_prog_word;
    next_prog_data  = o_prog_data;
    next_row_rd     = 1'b0;
    next_row_cal    = o_row_cal;
    next_row_addr   = o_row_addr;
    next_row_valid  = o_row_rd;
    next_row_data   = o_row_rd ? i_row_rdata : o_row_data;
    next_fuse_rd    = 1'b0;
    next_fuse_pend  = 1'b0;
    next_fuse_addr  = o_fuse_addr;
    next_dbz        = o_data_byte_zero_reg;
    next_lock       = o_lock_bits;
    next_ee_erase   = 1'b0;
    next_halt       = o_cpu_halt;
    buf_we          = 1'b0;
    buf_idx         = ptr_word;
    buf_wdata       = i_data_word_register_pair;
    case (state)
      S_IDLE:
      begin
        next_halt = 1'b0;
        if (i_store_program_memory_instr && i_cmd == `CMD_LOAD_FBUF)
          buf_we = 1'b1;
        if (i_load_program_memory_instr
            && (i_cmd == `CMD_READ_USER_SIG || i_cmd == `CMD_READ_CALIB))
        begin
          next_row_rd   = 1'b1;
          next_row_cal  = (i_cmd == `CMD_READ_CALIB);
          next_row_addr = i_pointer;
        end
        next_page       = ptr_page;
        next_sig_op     = 1'b0;
        next_prog_after = 1'b0;
        next_halt_prog  = 1'b0;
        next_cnt        = '0;
        if (spm_ok)
        begin
          case (i_cmd)
            `CMD_ERASE_APP:
            if (in_app)
            begin
              next_state     = S_ERASE;
              next_erase_req = 1'b1;
              next_erase_all = 1'b1;
              next_halt      = 1'b1;
            end
            else
              next_abort = 1'b1;
            `CMD_ERASE_FL_PG, `CMD_WRITE_FL_PG, `CMD_ERWR_FL_PG,
            `CMD_ERASE_APP_PG, `CMD_WRITE_APP_PG, `CMD_ERWR_APP_PG,
            `CMD_ERASE_BOOT_PG, `CMD_WRITE_BOOT_PG, `CMD_ERWR_BOOT_PG:
            if ((!in_app && (i_cmd == `CMD_ERASE_APP_PG
                 || i_cmd == `CMD_WRITE_APP_PG
                 || i_cmd == `CMD_ERWR_APP_PG))
                || (in_app && (i_cmd == `CMD_ERASE_BOOT_PG
                 || i_cmd == `CMD_WRITE_BOOT_PG
                 || i_cmd == `CMD_ERWR_BOOT_PG)))
              next_abort = 1'b1;
            else if (i_cmd == `CMD_WRITE_FL_PG
                     || i_cmd == `CMD_WRITE_APP_PG
                     || i_cmd == `CMD_WRITE_BOOT_PG)
            begin
              next_state     = S_PROG;
              next_halt      = !in_app;
              next_halt_prog = !in_app;
            end
            else
            begin
              next_state      = S_ERASE;
              next_erase_req  = 1'b1;
              next_halt       = !in_app;
              next_halt_prog  = !in_app;
              next_prog_after = (i_cmd == `CMD_ERWR_FL_PG
                                 || i_cmd == `CMD_ERWR_APP_PG
                                 || i_cmd == `CMD_ERWR_BOOT_PG);
            end
            `CMD_ERASE_USER_SIG:
            begin
              next_state     = S_ERASE;
              next_erase_req = 1'b1;
              next_erase_sig = 1'b1;
              next_sig_op    = 1'b1;
              next_halt      = 1'b1;
            end
            `CMD_WRITE_USER_SIG:
            begin
              next_state     = S_PROG;
              next_sig_op    = 1'b1;
              next_halt      = 1'b1;
              next_halt_prog = 1'b1;
            end
            default:
              next_state = S_IDLE;
          endcase
        end
        else if (cex_ok)
        begin
          case (i_cmd)
            `CMD_ERASE_FBUF:
              next_state = S_CLEAR;
            `CMD_READ_FUSES:
            begin
              next_state     = S_FUSE;
              next_fuse_rd   = 1'b1;
              next_fuse_addr = i_fuse_addr;
              next_halt      = 1'b1;
            end
            `CMD_WRITE_LOCK:
            begin
              next_state = S_LOCK;
              next_halt  = 1'b1;
            end
            default:
              next_state = S_IDLE;
          endcase
        end
      end
      S_ERASE:
      begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(ERASE_CYCLES - 1))
        begin
          next_cnt   = '0;
          next_state = next_prog_after ? S_PROG : S_IDLE;
          next_halt  = prog_after && halt_prog;
        end
      end
      S_PROG:
      begin
        // Extra cycle keeps busy over the last word strobe
        if (cnt == CNT_W'(PAGE_WORDS))
        begin
          next_cnt   = '0;
          next_state = sig_op ? S_CLEAR : S_IDLE;
          next_halt  = 1'b0;
        end
        else
        begin
          next_prog_we   = 1'b1;
          next_prog_sig  = sig_op;
          next_prog_word = cnt[WORD_BITS-1:0];
          next_prog_data = pbuf[cnt[WORD_BITS-1:0]];
          next_cnt       = cnt + 1'b1;
        end
      end
      S_CLEAR:
      begin
        buf_we    = 1'b1;
        buf_idx   = cnt[WORD_BITS-1:0];
        buf_wdata = `ERASED_WORD;
        next_cnt  = cnt + 1'b1;
        if (cnt == CNT_W'(PAGE_WORDS - 1))
        begin
          next_cnt   = '0;
          next_state = S_IDLE;
          next_halt  = 1'b0;
        end
      end
      S_FUSE:
      begin
        next_fuse_pend = 1'b1;
        if (fuse_pend)
        begin
          next_dbz       = i_fuse_rdata;
          next_fuse_pend = 1'b0;
          next_state     = S_IDLE;
          next_halt      = 1'b0;
        end
      end
      S_LOCK:
      begin
        next_lock     = o_lock_bits & i_data_byte_zero_reg;
        next_ee_erase = 1'b1;
        next_state    = S_CLEAR;
      end
      default:
        next_state = S_IDLE;
    endcase
    next_busy  = (next_state != S_IDLE);
    next_flash_section_busy_flag = next_busy && !next_sig_op
                 && (next_state == S_ERASE || next_state == S_PROG);
  end

  always_ff @(posedge i_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state                     <= S_IDLE;
      cnt                       <= '0;
      prog_after                <= 1'b0;
      sig_op                    <= 1'b0;
      halt_prog                 <= 1'b0;
      fuse_pend                 <= 1'b0;
      o_busy                    <= 1'b0;
      o_flash_section_busy_flag <= 1'b0;
      o_app_blocked             <= 1'b0;
      o_cpu_halt                <= 1'b0;
      o_abort                   <= 1'b0;
      o_erase_req               <= 1'b0;
      o_erase_all_app           <= 1'b0;
      o_erase_sig               <= 1'b0;
      o_prog_we                 <= 1'b0;
      o_prog_sig                <= 1'b0;
      o_page                    <= '0;
      o_prog_word               <= '0;
      o_prog_data               <= `ERASED_WORD;
      o_row_rd                  <= 1'b0;
      o_row_cal                 <= 1'b0;
      o_row_addr                <= '0;
      o_row_data                <= 8'h00;
      o_row_valid               <= 1'b0;
      o_fuse_rd                 <= 1'b0;
      o_fuse_addr               <= 8'h00;
      o_data_byte_zero_reg      <= 8'h00;
      o_lock_bits               <= `LOCK_RESET;
      o_eeprom_buf_erase        <= 1'b0;
    end
    else
    begin
      state                     <= next_state;
      cnt                       <= next_cnt;
      prog_after                <= next_prog_after;
      sig_op                    <= next_sig_op;
      halt_prog                 <= next_halt_prog;
      fuse_pend                 <= next_fuse_pend;
      o_busy                    <= next_busy;
      o_flash_section_busy_flag <= next_flash_section_busy_flag;
      o_app_blocked             <= next_flash_section_busy_flag;
      o_cpu_halt                <= next_halt;
      o_abort                   <= next_abort;
      o_erase_req               <= next_erase_req;
      o_erase_all_app           <= next_erase_all;
      o_erase_sig               <= next_erase_sig;
      o_prog_we                 <= next_prog_we;
      o_prog_sig                <= next_prog_sig;
      o_page                    <= next_page;
      o_prog_word               <= next_prog_word;
      o_prog_data               <= next_prog_data;
      o_row_rd                  <= next_row_rd;
      o_row_cal                 <= next_row_cal;
      o_row_addr                <= next_row_addr;
      o_row_data                <= next_row_data;
      o_row_valid               <= next_row_valid;
      o_fuse_rd                 <= next_fuse_rd;
      o_fuse_addr               <= next_fuse_addr;
      o_data_byte_zero_reg      <= next_dbz;
      o_lock_bits               <= next_lock;
      o_eeprom_buf_erase        <= next_ee_erase;
    end
  end

endmodule

/* File: bench/flash_seq_properties.sv */
// Purpose: Port-level checks for the flash sequencer
// Assumes: Triggers come only after internal reset release
// Notes:   Bound from the bench top file
`timescale 1ns/10ps
module flash_seq_properties
#(
  parameter int WORD_BITS = 6,
  parameter int BOOT_PAGE = 480
)
(
  input wire logic                 i_clk,
  input wire logic                 i_rstn,
  input wire flash_seq_pkg::cmd_t  i_cmd,
  input wire logic                 i_store_program_memory_instr,
  input wire logic                 i_load_program_memory_instr,
  input wire logic                 i_command_execute_bit,
  input wire logic                 i_change_protection_sequence,
  input wire logic [15:0]          i_pointer,
  input wire logic                 o_busy,
  input wire logic                 o_flash_section_busy_flag,
  input wire logic                 o_app_blocked,
  input wire logic                 o_cpu_halt,
  input wire logic                 o_abort,
  input wire logic                 o_erase_req,
  input wire logic                 o_erase_all_app,
  input wire logic [14-WORD_BITS:0] o_page,
  input wire logic                 o_row_rd,
  input wire logic [15:0]          o_row_addr,
  input wire logic                 o_row_valid,
  input wire logic                 o_fuse_rd,
  input wire logic [7:0]           o_lock_bits
);
  import flash_seq_pkg::*;
  logic        idle;
  logic [15:0] pg;
  assign idle = !o_busy && !o_cpu_halt;
  assign pg   = i_pointer >> (WORD_BITS + 1);
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  //////////////////////////////////////////////////////////////////////
  chk_page_start: assert property (
    i_store_program_memory_instr && i_cmd == 7'h25 && idle &&
    i_change_protection_sequence && pg < BOOT_PAGE |=> o_busy &&
    o_flash_section_busy_flag && o_erase_req && 16'(o_page) == $past(pg))
    else $error("page start wrong");
  chk_blocked_match: assert property (
    o_app_blocked == o_flash_section_busy_flag)
    else $error("blocked differs from flash busy");
  chk_flash_section_busy_flag_in_busy: assert property (
    o_flash_section_busy_flag |-> o_busy)
    else $error("flash busy without busy");
  chk_load_quiet: assert property (
    i_store_program_memory_instr && i_cmd == 7'h23 && idle
    |=> !o_busy && !o_cpu_halt)
    else $error("buffer load went busy");
  chk_row_read: assert property (
    i_load_program_memory_instr && i_cmd == 7'h01 && idle
    |=> o_row_rd && o_row_addr == $past(i_pointer) ##1 o_row_valid)
    else $error("row read wrong");
  chk_fuse_halt: assert property (
    i_command_execute_bit && i_cmd == 7'h07 && idle &&
    i_change_protection_sequence |=> o_fuse_rd && o_busy && o_cpu_halt)
    else $error("fuse read start wrong");
  chk_lock_secure: assert property (
    $changed(o_lock_bits) |-> (o_lock_bits & ~$past(o_lock_bits)) == 8'h00)
    else $error("lock bits loosened");
  chk_busy_ignore: assert property (
    o_busy && i_load_program_memory_instr |=> !o_row_rd)
    else $error("trigger taken while busy");
  chk_abort_boot: assert property (
    i_store_program_memory_instr && i_cmd == 7'h2D && idle &&
    i_change_protection_sequence && pg < BOOT_PAGE |=> o_abort && !o_busy)
    else $error("boot command on app page not aborted");
  chk_app_erase: assert property (
    o_erase_all_app |-> o_cpu_halt && o_busy)
    else $error("app erase without halt");
  cover property (o_abort);
  cover property (o_row_valid);
  cover property (o_erase_all_app);
endmodule

/* File: bench/flash_far_model.sv */
// Purpose: Rows and fuses beside the sequencer
// Assumes: Row byte wanted with its strobe, fuse byte the cycle after
// Notes:   Between reads the lines toggle, never hold data
`timescale 1ns/10ps
module flash_far_model
(
  input  wire logic        i_clk,
  input  wire logic        i_row_rd,
  input  wire logic        i_row_cal,
  input  wire logic [15:0] i_row_addr,
  input  wire logic        i_fuse_rd,
  input  wire logic [7:0]  i_fuse_addr,
  output logic [7:0]       o_row_rdata,
  output logic [7:0]       o_fuse_rdata
);
  logic [7:0] row_idle = 8'h00;
  // one row byte, standing while the strobe does
  assign o_row_rdata = i_row_rd ? {i_row_cal, i_row_addr[6:0]} : row_idle;
  initial
    o_fuse_rdata = 8'h00;
  always @(posedge i_clk)
  begin
    row_idle <= ~row_idle;
    o_fuse_rdata <= i_fuse_rd ? i_fuse_addr ^ 8'h5A : ~o_fuse_rdata;
  end
endmodule

/* File: bench/flash_self_program_sequencer_test.sv */
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Four-word page and short erase for run time
// Notes:   Checker bound below the module
`timescale 1ns/10ps
module flash_self_program_sequencer_test;
  import flash_seq_pkg::*;
  logic        i_clk = 1'b0;
  logic        i_rstn = 1'b0;
  cmd_t        i_cmd = 7'h00;
  logic [2:0]  trg = 3'h0;
  logic        i_change_protection_sequence = 1'b0;
  logic [15:0] i_pointer = 16'h0000;
  logic [15:0] i_data_word_register_pair = 16'h0000;
  logic [7:0]  i_data_byte_zero_reg = 8'h00;
  logic [7:0]  i_fuse_addr = 8'h05;
  logic [7:0]  i_row_rdata, i_fuse_rdata, o_row_data, o_fuse_addr;
  logic [7:0]  o_data_byte_zero_reg, o_lock_bits;
  logic        o_busy, o_flash_section_busy_flag, o_app_blocked, o_cpu_halt;
  logic        o_abort, o_erase_req, o_erase_all_app, o_prog_we, o_row_rd;
  logic        o_row_cal, o_row_valid, o_fuse_rd, o_eeprom_buf_erase;
  logic        o_erase_sig, o_prog_sig;
  logic [12:0] o_page;
  logic [1:0]  o_prog_word;
  logic [15:0] o_prog_data, o_row_addr;
  logic [15:0] exp [4] = '{16'h1234, 16'hFFFF, 16'hABCD, 16'hFFFF};
  // Entries: halt, trigger kind, boot page, command
  logic [10:0] tbl [14] = '{11'h420, 11'h022, 11'h024, 11'h025, 11'h4AA,
    11'h4AB, 11'h4AC, 11'h4AD, 11'h02E, 11'h02F, 11'h418, 11'h41A,
    11'h226, 11'h607};
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          n_ee = 0;
  int          n;
  flash_self_program_sequencer #(.WORD_BITS(2), .ERASE_CYCLES(4)) DUT (
    .i_clk, .i_rstn, .i_cmd, .i_command_execute_bit(trg[2]),
    .i_store_program_memory_instr(trg[0]),
    .i_load_program_memory_instr(trg[1]),
    .i_change_protection_sequence, .i_pointer,
    .i_data_word_register_pair, .i_data_byte_zero_reg, .i_fuse_addr,
    .i_row_rdata, .i_fuse_rdata, .o_busy, .o_flash_section_busy_flag,
    .o_app_blocked, .o_cpu_halt, .o_abort, .o_erase_req, .o_erase_all_app,
    .o_erase_sig, .o_prog_we, .o_prog_sig, .o_page, .o_prog_word,
    .o_prog_data, .o_row_rd, .o_row_cal, .o_row_addr, .o_row_data,
    .o_row_valid, .o_fuse_rd, .o_fuse_addr, .o_data_byte_zero_reg,
    .o_lock_bits, .o_eeprom_buf_erase);
  flash_far_model FAR (.i_clk, .i_row_rd(o_row_rd), .i_row_cal(o_row_cal),
    .i_row_addr(o_row_addr), .i_fuse_rd(o_fuse_rd),
    .i_fuse_addr(o_fuse_addr), .o_row_rdata(i_row_rdata),
    .o_fuse_rdata(i_fuse_rdata));
  initial
    forever #2 i_clk = ~i_clk;
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Pulse one trigger; returns just after the answering edge
  task automatic trig(input int k, input cmd_t c, input logic [15:0] p, d);
    @(posedge i_clk);
    i_cmd <= c;
    i_pointer <= p;
    i_data_word_register_pair <= d;
    i_data_byte_zero_reg <= d[7:0];
    i_change_protection_sequence <= !(c inside {7'h23, 7'h01, 7'h02});
    trg <= 3'h1 << k;
    @(posedge i_clk);
    trg <= 3'h0;
    #1;
  endtask
  task automatic wait_idle;
    int i;
    i = 0;
    while ((o_busy !== 1'b0 || o_cpu_halt !== 1'b0) && i < 200)
    begin
      @(posedge i_clk);
      #1;
      i++;
    end
    chk("idle", 16'h0, {15'h0, o_busy});
  endtask
  task automatic summarize;
    if (miscompares == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (o_eeprom_buf_erase === 1'b1)
      n_ee <= n_ee + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (3) @(posedge i_clk);
    trig(0, 7'h23, 16'h0028, 16'h1234);
    trig(0, 7'h23, 16'h002C, 16'hABCD);
    trig(0, 7'h25, 16'h002F, 16'h0000);
    chk("erase_req", 16'h1, {15'h0, o_erase_req});
    chk("page", 16'h5, 16'(o_page));
    trig(1, 7'h01, 16'h0F00, 16'h0000);
    chk("row_rd", 16'h0, {15'h0, o_row_rd});
    n = 0;
    for (int i = 0; i < 60 && o_busy === 1'b1; i++)
    begin
      if (o_prog_we === 1'b1)
      begin
        chk("word", 16'(n), 16'(o_prog_word));
        chk("data", exp[n], o_prog_data);
        chk("page", 16'h5, 16'(o_page));
        n++;
      end
      @(posedge i_clk);
      #1;
    end
    chk("words", 16'h4, 16'(n));
    wait_idle();
    for (int j = 0; j < 14; j++)
    begin
      trig(tbl[j][9:8], tbl[j][6:0], tbl[j][7] ? 16'h0F00 : 16'h0028, 0);
      chk("busy", 16'h1, {15'h0, o_busy});
      chk("halt", {15'h0, tbl[j][10]}, {15'h0, o_cpu_halt});
      chk("erase_sig", 16'(tbl[j][6:0] == 7'h18), {15'h0, o_erase_sig});
      wait_idle();
    end
    chk("fuse", 16'h005F, 16'(o_data_byte_zero_reg));
    chk("prog_sig", 16'h1, {15'h0, o_prog_sig});
    trig(0, 7'h2D, 16'h0028, 16'h0);
    chk("abort", 16'h1, {15'h0, o_abort});
    trig(0, 7'h22, 16'h0F00, 16'h0);
    chk("abort", 16'h1, {15'h0, o_abort});
    chk("busy", 16'h0, {15'h0, o_busy});
    for (int j = 1; j < 3; j++)
    begin
      trig(1, 7'(j), 16'h0013, 16'h0);
      @(posedge i_clk);
      #1;
      chk("row_valid", 16'h1, {15'h0, o_row_valid});
      chk("row_data", j == 1 ? 16'h13 : 16'h93, 16'(o_row_data));
    end
    trig(2, 7'h08, 16'h0, 16'h003C);
    wait_idle();
    chk("lock", 16'h003C, 16'(o_lock_bits));
    trig(2, 7'h08, 16'h0, 16'h00C3);
    wait_idle();
    chk("lock", 16'h0000, 16'(o_lock_bits));
    chk("ee_erase", 16'h2, 16'(n_ee));
    summarize();
  end
endmodule

bind flash_self_program_sequencer flash_seq_properties
  #(.WORD_BITS(WORD_BITS), .BOOT_PAGE(BOOT_PAGE)) CHK (.i_clk, .i_rstn,
  .i_cmd, .i_store_program_memory_instr, .i_load_program_memory_instr,
  .i_command_execute_bit, .i_change_protection_sequence, .i_pointer,
  .o_busy, .o_flash_section_busy_flag, .o_app_blocked, .o_cpu_halt,
  .o_abort, .o_erase_req, .o_erase_all_app, .o_page, .o_row_rd,
  .o_row_addr, .o_row_valid, .o_fuse_rd, .o_lock_bits);
